/* File: design/imrt_top.sv */
// Contract
// - restart: pull SCL low, then start counting
// - release SDA one period, then SCL
// - both high one period, SDA low period
// - restart end: clear request, SDA stays low
// - start flag at once, irq after timeout
// - restart ignored while port is busy
// - restart collision: SDA low or early SCL
// - buffer write sets full, starts shifting
// - bit after SCL falls, low/high periods
// - eighth fall: clear full, release SDA
// - ninth clock acknowledge into ack status
// - after ninth clock: irq, hold SCL low
// - busy buffer write: collision flag, dropped
// - receive request ignored unless idle
// - receive toggles SCL per rollover, shifts
// - receive end: copy, full, irq, idle
// - reading buffer clears full flag
// - overflow when byte lands on full buffer
// - buffer write while receiving: collision
// - stop or restart completion raises irq
// - counter loads from baud reload low byte
// - counter reloads until SCL really high
// - collision sets flag, port goes idle
`timescale 1ns/1ps
`default_nettype none
module imrt_top
  import imrt_pkg::*;
(
  input  wire logic        mclk,          // system clock
  input  wire logic        resetn,        // async reset, active low
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic        scl_i,         // SCL line level
  output logic             scl_o,         // SCL drive value
  output logic             scl_oe,        // SCL driven low
  input  wire logic        sda_i,         // SDA line level
  output logic             sda_o,         // SDA drive value
  output logic             sda_oe         // SDA driven low
);

  // ---------------------------------------------------------------
  // reset and pin synchronisers
  // ---------------------------------------------------------------
  logic       rst_meta_ff, rst_n_ff;
  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic       scl_s, sda_s, scl_d_ff, sda_d_ff;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
      scl_d_ff    <= scl_s;
      sda_d_ff    <= sda_s;
    end
  end
  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic        wr_fire_ff, rd_buf_ff, ack_value_ff;
  logic [7:0]  wr_addr_ff, wr_data_ff, baud_ff;
  logic        wr_fire, ar_fire;

  imrt_state_t state_ff;
  logic [7:0]  buf_ff, shreg_ff, cnt_ff;
  logic [7:0]  status;
  logic [7:0]  ctrl_rd;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == MASTER_CONTROL_OFS) || (a == PORT_STATUS_OFS) ||
             (a == TRANSFER_BUFFER_OFS) || (a == BAUD_RELOAD_OFS);
  endfunction

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign ar_fire = s_axi_arvalid && !rvalid_ff;

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      aw_held_ff   <= 1'b0;
      w_held_ff    <= 1'b0;
      bvalid_ff    <= 1'b0;
      awaddr_ff    <= 8'h00;
      wdata_ff     <= 32'h0000_0000;
      bresp_ff     <= RESP_OKAY;
      wr_fire_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
      wr_data_ff   <= 8'h00;
      baud_ff      <= BAUD_RELOAD_RST;
      ack_value_ff <= 1'b0;
    end else begin
      wr_fire_ff <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
        if (mapped(awaddr_ff) && s_axi_wstrb[0]) begin
          wr_fire_ff <= 1'b1;
          wr_addr_ff <= awaddr_ff;
          wr_data_ff <= wdata_ff[7:0];
          if (awaddr_ff == BAUD_RELOAD_OFS)
            baud_ff <= wdata_ff[7:0];
          if (awaddr_ff == MASTER_CONTROL_OFS)
            ack_value_ff <= wdata_ff[CTL_ACKVAL];
        end
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
      rd_buf_ff <= 1'b0;
    end else begin
      rd_buf_ff <= 1'b0;
      if (ar_fire) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata_ff  <= 32'h0000_0000;
        case ({s_axi_araddr[7:2], 2'h0})
          MASTER_CONTROL_OFS:  rdata_ff[7:0] <= ctrl_rd;
          PORT_STATUS_OFS:     rdata_ff[7:0] <= status;
          TRANSFER_BUFFER_OFS: begin
            rdata_ff[7:0] <= buf_ff;
            rd_buf_ff     <= 1'b1;
          end
          BAUD_RELOAD_OFS:     rdata_ff[7:0] <= baud_ff;
          default:             rdata_ff <= 32'h0000_0000;
        endcase
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // master sequencer
  // ---------------------------------------------------------------
  logic       scl_low_ff, sda_low_ff, scl_seen_ff;
  logic [3:0] bit_ff;
  logic       ev_irq_ff, ev_bcl_ff, ev_write_collision_flag_ff, ev_bfset_ff, ev_bfclr_ff;
  logic       ev_ack_ff, ev_ackval_ff, ev_rx_ff;
  logic       idle, tick, cmd_wr, buf_wr, hi_wait;

  // requests read back from the sequencer, so they self-clear
  assign idle    = (state_ff == ST_IDLE);
  assign tick    = (cnt_ff == 8'h00);
  assign cmd_wr  = wr_fire_ff && (wr_addr_ff == MASTER_CONTROL_OFS);
  assign buf_wr  = wr_fire_ff && (wr_addr_ff == TRANSFER_BUFFER_OFS);
  assign hi_wait = !scl_low_ff && !scl_s &&
                   (state_ff == ST_TX_HI || state_ff == ST_RX_HI ||
                    state_ff == ST_AK_HI || state_ff == ST_SP_HI ||
                    state_ff == ST_RS_SCLHI);
  assign ctrl_rd = {2'h0, ack_value_ff,
                    state_ff == ST_AK_LO || state_ff == ST_AK_HI,
                    state_ff == ST_RX_LO || state_ff == ST_RX_HI,
                    state_ff == ST_SP_LO || state_ff == ST_SP_HI ||
                    state_ff == ST_SP_SDA,
                    state_ff == ST_RS_SCLLO || state_ff == ST_RS_SDAHI ||
                    state_ff == ST_RS_SCLHI || state_ff == ST_RS_SDALO,
                    state_ff == ST_SB_WAIT || state_ff == ST_SB_LOW};

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      scl_seen_ff <= 1'b0;
      bit_ff <= 4'h0;
      shreg_ff <= 8'h00;
      buf_ff <= 8'h00;
      {ev_irq_ff, ev_bcl_ff, ev_write_collision_flag_ff, ev_bfset_ff} <= 4'h0;
      {ev_bfclr_ff, ev_ack_ff, ev_ackval_ff, ev_rx_ff} <= 4'h0;
    end else begin
      {ev_irq_ff, ev_bcl_ff, ev_write_collision_flag_ff, ev_bfset_ff} <= 4'h0;
      {ev_bfclr_ff, ev_ack_ff, ev_ackval_ff, ev_rx_ff} <= 4'h0;
      if (!idle && !tick)
        cnt_ff <= cnt_ff - 8'h01;
      if (hi_wait)
        cnt_ff <= baud_ff;
      if (buf_wr && !idle)
        ev_write_collision_flag_ff <= 1'b1;
      case (state_ff)
        ST_IDLE: begin
          cnt_ff <= baud_ff;
          scl_seen_ff <= 1'b0;
          if (cmd_wr && wr_data_ff[CTL_START]) begin
            if (!(scl_s && sda_s)) begin
              ev_bcl_ff <= 1'b1;
            end else begin
              scl_low_ff <= 1'b0;
              sda_low_ff <= 1'b0;
              state_ff <= ST_SB_WAIT;
            end
          end else if (cmd_wr && wr_data_ff[CTL_RESTART]) begin
            scl_low_ff <= 1'b1;
            state_ff <= ST_RS_SCLLO;
          end else if (cmd_wr && wr_data_ff[CTL_STOP]) begin
            sda_low_ff <= 1'b1;
            state_ff <= ST_SP_LO;
          end else if (cmd_wr && wr_data_ff[CTL_RECV]) begin
            scl_low_ff <= 1'b1;
            sda_low_ff <= 1'b0;
            bit_ff <= 4'h0;
            state_ff <= ST_RX_LO;
          end else if (cmd_wr && wr_data_ff[CTL_ACKSEQ]) begin
            scl_low_ff <= 1'b1;
            sda_low_ff <= !ack_value_ff;
            state_ff <= ST_AK_LO;
          end else if (buf_wr) begin
            buf_ff <= wr_data_ff;
            shreg_ff <= {wr_data_ff[6:0], 1'b0};
            ev_bfset_ff <= 1'b1;
            scl_low_ff <= 1'b1;
            sda_low_ff <= !wr_data_ff[7];
            bit_ff <= 4'h0;
            state_ff <= ST_TX_LO;
          end
        end
        ST_SB_WAIT: begin
          if (!scl_s || !sda_s) begin
            ev_bcl_ff <= 1'b1;
          end else if (tick) begin
            sda_low_ff <= 1'b1;
            cnt_ff <= baud_ff;
            state_ff <= ST_SB_LOW;
          end
        end
        ST_SB_LOW: begin
          if (tick) begin
            scl_low_ff <= 1'b1;
            ev_irq_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        ST_RS_SCLLO: begin
          cnt_ff <= baud_ff;
          if (!scl_s) begin
            sda_low_ff <= 1'b0;
            state_ff <= ST_RS_SDAHI;
          end
        end
        ST_RS_SDAHI: begin
          if (tick) begin
            if (sda_s) begin
              scl_low_ff <= 1'b0;
              cnt_ff <= baud_ff;
              state_ff <= ST_RS_SCLHI;
            end else begin
              ev_bcl_ff <= 1'b1;
            end
          end
        end
        ST_RS_SCLHI: begin
          if (scl_s)
            scl_seen_ff <= 1'b1;
          if ((scl_s && !sda_s) || (scl_seen_ff && !scl_s)) begin
            ev_bcl_ff <= 1'b1;
          end else if (scl_s && tick) begin
            sda_low_ff <= 1'b1;
            cnt_ff <= baud_ff;
            state_ff <= ST_RS_SDALO;
          end
        end
        ST_RS_SDALO: begin
          if (!scl_s) begin
            ev_bcl_ff <= 1'b1;
          end else if (tick) begin
            scl_low_ff <= 1'b1;
            ev_irq_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        ST_TX_LO, ST_RX_LO, ST_AK_LO: begin
          if (tick) begin
            scl_low_ff <= 1'b0;
            cnt_ff <= baud_ff;
            state_ff <= (state_ff == ST_TX_LO) ? ST_TX_HI :
                        (state_ff == ST_RX_LO) ? ST_RX_HI : ST_AK_HI;
          end
        end
        ST_TX_HI: begin
          if (scl_s && !sda_low_ff && !sda_s && bit_ff != ACK_BIT) begin
            ev_bcl_ff <= 1'b1;
          end else if (scl_s && tick) begin
            scl_low_ff <= 1'b1;
            cnt_ff <= baud_ff;
            if (bit_ff == ACK_BIT) begin
              ev_ack_ff <= 1'b1;
              ev_ackval_ff <= sda_s;
              ev_irq_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end else begin
              bit_ff <= bit_ff + 4'h1;
              state_ff <= ST_TX_LO;
              if (bit_ff == LAST_DATA_BIT) begin
                sda_low_ff <= 1'b0;
                ev_bfclr_ff <= 1'b1;
              end else begin
                sda_low_ff <= !shreg_ff[7];
                shreg_ff <= {shreg_ff[6:0], 1'b0};
              end
            end
          end
        end
        ST_RX_HI: begin
          if (scl_s && tick) begin
            scl_low_ff <= 1'b1;
            cnt_ff <= baud_ff;
            shreg_ff <= {shreg_ff[6:0], sda_s};
            bit_ff <= bit_ff + 4'h1;
            state_ff <= ST_RX_LO;
            if (bit_ff == LAST_DATA_BIT) begin
              buf_ff <= {shreg_ff[6:0], sda_s};
              ev_rx_ff <= 1'b1;
              ev_irq_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_AK_HI: begin
          if (scl_s && tick) begin
            scl_low_ff <= 1'b1;
            ev_irq_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        ST_SP_LO: begin
          if (sda_s)
            cnt_ff <= baud_ff;
          else if (tick) begin
            scl_low_ff <= 1'b0;
            cnt_ff <= baud_ff;
            state_ff <= ST_SP_HI;
          end
        end
        ST_SP_HI: begin
          if (scl_s && tick) begin
            sda_low_ff <= 1'b0;
            cnt_ff <= baud_ff;
            state_ff <= ST_SP_SDA;
          end
        end
        ST_SP_SDA: begin
          if (!sda_s)
            cnt_ff <= baud_ff;
          else if (tick) begin
            ev_irq_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
      // a lost arbitration releases both lines and abandons the sequence
      if (ev_bcl_ff) begin
        scl_low_ff <= 1'b0;
        sda_low_ff <= 1'b0;
        state_ff <= ST_IDLE;
      end
    end
  end

  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_low_ff;
  assign sda_oe = sda_low_ff;

  // ---------------------------------------------------------------
  // status flags, set wins over software clear
  // ---------------------------------------------------------------
  logic bf_ff, write_collision_flag_ff, ovf_ff, ackst_ff, irq_ff, bcl_ff, sdet_ff, pdet_ff;
  logic sta_wr;
  logic [7:0] w1c;

  assign sta_wr = wr_fire_ff && (wr_addr_ff == PORT_STATUS_OFS);
  assign w1c    = sta_wr ? wr_data_ff : 8'h00;
  assign status = {pdet_ff, sdet_ff, bcl_ff, irq_ff,
                   ackst_ff, ovf_ff, write_collision_flag_ff, bf_ff};

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bf_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
      ovf_ff <= 1'b0;
      ackst_ff <= 1'b0;
      irq_ff <= 1'b0;
      bcl_ff <= 1'b0;
      sdet_ff <= 1'b0;
      pdet_ff <= 1'b0;
    end else begin
      if (ev_bfset_ff || ev_rx_ff)
        bf_ff <= 1'b1;
      else if (ev_bfclr_ff || rd_buf_ff || ev_bcl_ff)
        bf_ff <= 1'b0;
      if (ev_rx_ff && bf_ff)
        ovf_ff <= 1'b1;
      else if (w1c[STA_OVF])
        ovf_ff <= 1'b0;
      if (ev_write_collision_flag_ff)
        write_collision_flag_ff <= 1'b1;
      else if (w1c[STA_WRITE_COLLISION_FLAG])
        write_collision_flag_ff <= 1'b0;
      if (ev_ack_ff)
        ackst_ff <= ev_ackval_ff;
      if (ev_irq_ff)
        irq_ff <= 1'b1;
      else if (w1c[STA_IRQ])
        irq_ff <= 1'b0;
      if (ev_bcl_ff)
        bcl_ff <= 1'b1;
      else if (w1c[STA_BCL])
        bcl_ff <= 1'b0;
      if (scl_s && scl_d_ff && sda_d_ff && !sda_s) begin
        sdet_ff <= 1'b1;
        pdet_ff <= 1'b0;
      end else if (scl_s && scl_d_ff && !sda_d_ff && sda_s) begin
        pdet_ff <= 1'b1;
        sdet_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_restart_scl_low: assert property (@(posedge mclk) disable iff (!rst_n_ff)
    state_ff == ST_RS_SCLLO |-> scl_oe)
    else $error("restart does not pull SCL low");
  a_restart_busy: assert property (@(posedge mclk) disable iff (!rst_n_ff)
    (cmd_wr && !idle && state_ff != ST_RS_SCLLO) |=> state_ff != ST_RS_SCLLO)
    else $error("restart accepted while busy");
  a_restart_end: assert property (@(posedge mclk) disable iff (!rst_n_ff)
    (state_ff == ST_RS_SDALO && tick && scl_s && !ev_bcl_ff) |=>
      (idle && scl_oe && sda_oe && ev_irq_ff))
    else $error("restart end state wrong");
  a_write_collision_flag_busy: assert property (@(posedge mclk) disable iff (!rst_n_ff)
    (buf_wr && !idle) |-> ##2 write_collision_flag_ff)
    else $error("busy buffer write not flagged");
  a_bf_on_write: assert property (@(posedge mclk) disable iff (!rst_n_ff)
    (buf_wr && idle && !cmd_wr && !ev_bcl_ff) |=> state_ff == ST_TX_LO ##1 bf_ff)
    else $error("buffer write did not start transmit");
  a_stretch_hold: assert property (@(posedge mclk) disable iff (!rst_n_ff)
    (hi_wait && !ev_bcl_ff) |=> (cnt_ff == $past(baud_ff) &&
                                 state_ff == $past(state_ff)))
    else $error("counter ran while SCL held low");
  a_rx_done_idle: assert property (@(posedge mclk) disable iff (!rst_n_ff)
    ev_rx_ff |-> (idle && scl_oe && buf_ff == shreg_ff) ##1 (bf_ff && irq_ff))
    else $error("receive completion wrong");
  a_ovf_set: assert property (@(posedge mclk) disable iff (!rst_n_ff)
    (ev_rx_ff && bf_ff) |=> ovf_ff)
    else $error("overflow not flagged");
  a_ack_capture: assert property (@(posedge mclk) disable iff (!rst_n_ff)
    ev_ack_ff |=> ackst_ff == $past(ev_ackval_ff))
    else $error("ack status not recorded");
  a_bcl_idle: assert property (@(posedge mclk) disable iff (!rst_n_ff)
    ev_bcl_ff |=> (idle && !scl_oe && !sda_oe && bcl_ff))
    else $error("collision did not idle the port");

endmodule
`default_nettype wire

/* File: common/imrt_pkg.sv */
`default_nettype none
package imrt_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] MASTER_CONTROL_OFS  = 8'h00;
  localparam logic [7:0] PORT_STATUS_OFS     = 8'h04;
  localparam logic [7:0] TRANSFER_BUFFER_OFS = 8'h08;
  localparam logic [7:0] BAUD_RELOAD_OFS     = 8'h0C;

  // master_control_reg fields
  localparam int CTL_START   = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_STOP    = 2;
  localparam int CTL_RECV    = 3;
  localparam int CTL_ACKSEQ  = 4;
  localparam int CTL_ACKVAL  = 5;

  // port_status_reg fields
  localparam int STA_BF      = 0;
  localparam int STA_WRITE_COLLISION_FLAG    = 1;
  localparam int STA_OVF     = 2;
  localparam int STA_ACK_STATUS_BIT = 3;
  localparam int STA_IRQ     = 4;
  localparam int STA_BCL     = 5;
  localparam int STA_SDET    = 6;
  localparam int STA_PDET    = 7;

  // reset values
  localparam logic [7:0] BAUD_RELOAD_RST = 8'h09;
  localparam logic [7:0] CTRL_RST        = 8'h00;

  // bit counts of a byte on the wire
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT       = 4'h8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE, ST_SB_WAIT, ST_SB_LOW,
    ST_RS_SCLLO, ST_RS_SDAHI, ST_RS_SCLHI, ST_RS_SDALO,
    ST_TX_LO, ST_TX_HI, ST_RX_LO, ST_RX_HI,
    ST_AK_LO, ST_AK_HI, ST_SP_LO, ST_SP_HI, ST_SP_SDA
  } imrt_state_t;

endpackage
`default_nettype wire

/* File: testbench/imrt_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module imrt_slave (
  input  wire logic       scl,     // resolved SCL level
  input  wire logic       sda,     // resolved SDA level
  input  wire logic       ack_en,  // acknowledge written bytes
  input  wire logic       rd_data, // slave sends data bytes
  input  wire logic [7:0] rd_byte, // byte sent when reading
  output logic            sda_oe   // high pulls SDA low
);
  logic [3:0] cnt;
  initial cnt = 4'h0;
  // a start resets the framing so the start's own SCL fall reads as 1
  always @(negedge sda) if (scl === 1'b1) cnt = 4'h0;
  always @(negedge scl) cnt = (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
  // released otherwise, so the pull-up shows rather than a stale level
  assign sda_oe = (cnt == 4'h9 && ack_en && !rd_data) ||
                  (rd_data && cnt >= 4'h1 && cnt <= 4'h8 &&
                   !rd_byte[4'h8 - cnt]);
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb import imrt_pkg::*; ;
  logic mclk, resetn, awv, wv, bready, arv, rready, ack_en, rd_data;
  logic awr, wr_rdy, bvalid, arr, rvalid, scl_oe, sda_oe, s_oe, scl, sda;
  logic [7:0]  awaddr, araddr, rd_byte;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, last_resp;
  int          err_count, n_compared, cyc;
  assign scl = !scl_oe;
  assign sda = !(sda_oe || s_oe);
  imrt_top u_imrt_top (.mclk(mclk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  imrt_slave u_imrt_slave (.scl(scl), .sda(sda), .ack_en(ack_en),
    .rd_data(rd_data), .rd_byte(rd_byte), .sda_oe(s_oe));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end
  task automatic ck(input logic [31:0] g, m, e);
    n_compared++;
    if ((g & m) !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, g & m, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awv <= 1'b1; wv <= 1'b1; awaddr <= a; wdata <= d;
    while (pa || pw) begin
      @(posedge mclk);
      if (pa && awr) begin pa = 1'b0; awv <= 1'b0; end
      if (pw && wr_rdy) begin pw = 1'b0; wv <= 1'b0; end
    end
    bready <= 1'b1;
    do @(posedge mclk); while (bvalid !== 1'b1);
    last_resp = bresp;
    bready <= 1'b0;
    // flags move two edges after the response, so let one more edge pass
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    arv <= 1'b1; araddr <= a;
    do @(posedge mclk); while (arr !== 1'b1);
    arv <= 1'b0; rready <= 1'b1;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic wirq();
    logic [31:0] s;
    s = '0;
    for (int i = 0; i < 300 && s[STA_IRQ] !== 1'b1; i++)
      rd(PORT_STATUS_OFS, s);
    ck(s, 32'h10, 32'h10);
    wr(PORT_STATUS_OFS, 32'h10);
  endtask
  task automatic go(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    wirq();
  endtask
  initial begin
    {resetn, awv, wv, bready, arv, rready, ack_en, rd_data} = '0;
    {awaddr, araddr, rd_byte, wdata} = '0;
    err_count = 0; n_compared = 0; cyc = 0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(BAUD_RELOAD_OFS, v); ck(v, 32'hFF, 32'h09);
    rd(8'h10, v); ck({30'h0, last_resp}, 32'h3, {30'h0, RESP_SLVERR});
    wr(BAUD_RELOAD_OFS, 32'h02);
    go(MASTER_CONTROL_OFS, 32'h01);
    rd(PORT_STATUS_OFS, v); ck(v, 32'h40, 32'h40);
    $display("start test done");
    ack_en = 1'b1;
    wr(TRANSFER_BUFFER_OFS, 32'hA4);
    rd(PORT_STATUS_OFS, v); ck(v, 32'h01, 32'h01);
    wr(TRANSFER_BUFFER_OFS, 32'h55);
    wr(MASTER_CONTROL_OFS, 32'h02);
    wirq();
    rd(PORT_STATUS_OFS, v); ck(v, 32'h0B, 32'h02);
    rd(MASTER_CONTROL_OFS, v); ck(v, 32'h1F, 32'h00);
    wr(PORT_STATUS_OFS, 32'h02);
    ack_en = 1'b0;
    go(TRANSFER_BUFFER_OFS, 32'h00);
    rd(PORT_STATUS_OFS, v); ck(v, 32'h08, 32'h08);
    $display("transmit test done");
    go(MASTER_CONTROL_OFS, 32'h02);
    rd(MASTER_CONTROL_OFS, v); ck(v, 32'h02, 32'h00);
    ck({30'h0, sda_oe, scl_oe}, 32'h3, 32'h3);
    $display("restart test done");
    ack_en = 1'b1;
    go(TRANSFER_BUFFER_OFS, 32'h5B);
    rd_data = 1'b1; rd_byte = 8'h3C;
    go(MASTER_CONTROL_OFS, 32'h08);
    rd(PORT_STATUS_OFS, v); ck(v, 32'h01, 32'h01);
    rd(TRANSFER_BUFFER_OFS, v); ck(v, 32'hFF, 32'h3C);
    rd(PORT_STATUS_OFS, v); ck(v, 32'h01, 32'h00);
    go(MASTER_CONTROL_OFS, 32'h10);
    rd_byte = 8'hC3;
    wr(MASTER_CONTROL_OFS, 32'h08);
    wr(TRANSFER_BUFFER_OFS, 32'h11);
    wirq();
    rd(PORT_STATUS_OFS, v); ck(v, 32'h07, 32'h03);
    wr(PORT_STATUS_OFS, 32'h02);
    go(MASTER_CONTROL_OFS, 32'h30);
    go(MASTER_CONTROL_OFS, 32'h08);
    rd(PORT_STATUS_OFS, v); ck(v, 32'h04, 32'h04);
    go(MASTER_CONTROL_OFS, 32'h30);
    rd_data = 1'b0;
    $display("receive test done");
    wr(MASTER_CONTROL_OFS, 32'h01);
    rd(PORT_STATUS_OFS, v); ck(v, 32'h21, 32'h20);
    $display("collision test done");
    go(MASTER_CONTROL_OFS, 32'h04);
    rd(PORT_STATUS_OFS, v); ck(v, 32'h80, 32'h80);
    $display("stop test done");
    close_out();
  end
endmodule
`default_nettype wire
